// >>> src/rsl_pkg.sv
// constants for the receive status latch and interrupt enable block
package rsl_pkg;
  // apb geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // register indexes; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_STATUS_ONE = 12'h124;
  localparam logic [ADDR_W-1:0] IDX_STATUS_TWO = 12'h126;
  localparam logic [ADDR_W-1:0] IDX_LATCH_ONE = 12'h128;
  localparam logic [ADDR_W-1:0] IDX_LATCH_TWO = 12'h12a;
  localparam logic [ADDR_W-1:0] IDX_ENABLE_ONE = 12'h12c;
  localparam logic [ADDR_W-1:0] IDX_ENABLE_TWO = 12'h12e;
  localparam logic [ADDR_W-1:0] IDX_CONTROL = 12'h130;
  // latch one field positions
  localparam int B_FORMAT_MISMATCH = 11;
  localparam int B_APP_ID = 10;
  localparam int B_IDLE = 9;
  localparam int B_UNFRAMED_ONES = 8;
  localparam int B_MULTIFRAME_LOST = 7;
  localparam int B_SEVERE_FRAME_ERR = 6;
  localparam int B_ALIGN_CHANGE = 5;
  localparam int B_FRAME_LOST = 4;
  localparam int B_REMOTE_DEFECT = 3;
  localparam int B_ALARM_IND = 2;
  localparam int B_OUT_OF_FRAME = 1;
  localparam int B_NO_INPUT_SIGNAL = 0;
  // latch two field positions
  localparam int B_CBIT_ERR = 11;
  localparam int B_FAR_BLOCK_ERR = 10;
  localparam int B_PBIT_ERR = 9;
  localparam int B_FRAME_ERR = 8;
  localparam int B_CBIT_COUNT = 3;
  localparam int B_FAR_BLOCK_COUNT = 2;
  localparam int B_PBIT_COUNT = 1;
  localparam int B_FRAME_COUNT = 0;
  // implemented bits of each register; the rest read zero
  localparam logic [REG_W-1:0] MASK_ONE = 16'h0fff;
  localparam logic [REG_W-1:0] MASK_TWO = 16'h0f0f;
  localparam logic [REG_W-1:0] MASK_M23_ZERO = 16'h0c0c;
  localparam logic [REG_W-1:0] RESET_REG = 16'h0000;
  // control register fields
  localparam int B_M23_MODE = 0;
  localparam int B_FE_SEL_LO = 1;
  localparam int B_GIE_LO = 4;
  localparam int FE_SEL_W = 2;
  localparam int GIE_W = 4;
  localparam logic [REG_W-1:0] MASK_CONTROL = 16'h00f7;
  // alignment word width from the frame counters
  localparam int ALIGN_W = 8;
endpackage : rsl_pkg

// >>> src/rsl_latch_irq.sv
// receive status change latches, interrupt enables and apb slave for one port
// How it works
// RULE1: format mismatch latch sets on rising status
// RULE2: app id latch sets on any change
// RULE3: idle latch sets on any change
// RULE4: unframed ones latch sets on any change
// RULE5: multiframe and severe frame latches on change
// RULE6: alignment latch sets on differing new alignment
// RULE7: frame lost and remote defect latch on change
// RULE8: alarm, out of frame, signal loss on change
// RULE9: cbit parity latch sets on detected error
// RULE10: far block latch sets on detected error
// RULE11: pbit parity latch sets on detected error
// RULE12: framing latch event picked by type select
// RULE13: cbit count latch on count nonzero rising
// RULE14: far block count latch on nonzero rising
// RULE15: pbit count latch on nonzero rising
// RULE16: framing count latch on nonzero rising
// RULE17: m23 mode holds cbit and far block latches zero
// RULE18: interrupt needs latch, enable and port enable
// RULE19: enables one means on, reset zero
// RULE20: count nonzero status reads one when count nonzero; in m23 mode cbit and far block counts read zero
// RULE21: latches clear by writing one only
// RULE22: interrupt is or of enabled set latches
//
// Local design decision: the APB slave port.
module rsl_latch_irq #(
  parameter int PORT_INDEX = 0 // which port_global_int_enable bit belongs to this port
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rsl_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [rsl_pkg::DATA_W-1:0] pwdata_in,
  output logic [rsl_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // real-time receive conditions, same clock
  input wire logic format_mismatch_status_in,
  input wire logic app_id_channel_status_in,
  input wire logic idle_signal_status_in,
  input wire logic unframed_ones_status_in,
  input wire logic multiframe_lost_status_in,
  input wire logic severe_frame_err_status_in,
  input wire logic frame_lost_status_in,
  input wire logic remote_defect_status_in,
  input wire logic alarm_indication_status_in,
  input wire logic out_of_frame_status_in,
  input wire logic no_input_signal_status_in,
  // error event pulses
  input wire logic cbit_parity_err_in,
  input wire logic far_block_err_in,
  input wire logic pbit_parity_err_in,
  input wire logic [3:0] frame_err_event_in,
  // count nonzero levels from the error counters
  input wire logic cbit_count_nonzero_in,
  input wire logic far_block_count_nonzero_in,
  input wire logic pbit_count_nonzero_in,
  input wire logic frame_count_nonzero_in,
  // frame counter alignment load
  input wire logic align_load_in,
  input wire logic [rsl_pkg::ALIGN_W-1:0] align_value_in,
  // port interrupt request
  output logic irq_out
);

  // zero to one transition only
  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction

  // byte address match for a register index
  function automatic logic hit(input logic [rsl_pkg::ADDR_W-1:0] addr,
                               input logic [rsl_pkg::ADDR_W-1:0] idx);
    hit = (addr == {idx[rsl_pkg::ADDR_W-3:0], 2'b00});
  endfunction

  // software visible registers
  logic [rsl_pkg::REG_W-1:0] latch_one; // rx_status_latch_one
  logic [rsl_pkg::REG_W-1:0] latch_two; // rx_status_latch_two
  logic [rsl_pkg::REG_W-1:0] enable_one; // rx_status_irq_enable_one
  logic [rsl_pkg::REG_W-1:0] enable_two; // second enable register
  logic [rsl_pkg::REG_W-1:0] control; // mode, type select, port enables
  // previous samples for change detection
  logic [rsl_pkg::REG_W-1:0] prev_one;
  logic [rsl_pkg::REG_W-1:0] prev_two;
  logic [rsl_pkg::ALIGN_W-1:0] prev_align; // last loaded alignment
  logic align_valid; // an alignment has been loaded since reset
  logic primed; // previous samples hold real values
  // assembled views
  logic [rsl_pkg::REG_W-1:0] status_one;
  logic [rsl_pkg::REG_W-1:0] status_two;
  logic [rsl_pkg::REG_W-1:0] set_one;
  logic [rsl_pkg::REG_W-1:0] set_two;
  logic [rsl_pkg::REG_W-1:0] clr_one;
  logic [rsl_pkg::REG_W-1:0] clr_two;
  logic [rsl_pkg::REG_W-1:0] next_latch_one;
  logic [rsl_pkg::REG_W-1:0] next_latch_two;
  logic [rsl_pkg::REG_W-1:0] rd_word;
  logic rd_hit;
  logic m23_mode;
  logic [rsl_pkg::FE_SEL_W-1:0] fe_sel;
  logic port_enable;
  logic wr_now; // write takes effect this edge
  logic next_irq;

  // control fields
  assign m23_mode = control[rsl_pkg::B_M23_MODE];
  assign fe_sel = control[rsl_pkg::B_FE_SEL_LO +: rsl_pkg::FE_SEL_W];
  assign port_enable = control[rsl_pkg::B_GIE_LO + PORT_INDEX];
  assign wr_now = psel_in & penable_in & pready_out & pwrite_in;

  // real-time status one, laid out like the latch
  always_comb
  begin
    status_one = rsl_pkg::RESET_REG;
    status_one[rsl_pkg::B_FORMAT_MISMATCH] = format_mismatch_status_in;
    status_one[rsl_pkg::B_APP_ID] = app_id_channel_status_in;
    status_one[rsl_pkg::B_IDLE] = idle_signal_status_in;
    status_one[rsl_pkg::B_UNFRAMED_ONES] = unframed_ones_status_in;
    status_one[rsl_pkg::B_MULTIFRAME_LOST] = multiframe_lost_status_in;
    status_one[rsl_pkg::B_SEVERE_FRAME_ERR] = severe_frame_err_status_in;
    status_one[rsl_pkg::B_FRAME_LOST] = frame_lost_status_in;
    status_one[rsl_pkg::B_REMOTE_DEFECT] = remote_defect_status_in;
    status_one[rsl_pkg::B_ALARM_IND] = alarm_indication_status_in;
    status_one[rsl_pkg::B_OUT_OF_FRAME] = out_of_frame_status_in;
    status_one[rsl_pkg::B_NO_INPUT_SIGNAL] = no_input_signal_status_in;
  end

  // count nonzero view; counters outside already flag one or more
  always_comb
  begin
    status_two = rsl_pkg::RESET_REG;
    status_two[rsl_pkg::B_CBIT_COUNT] = cbit_count_nonzero_in; // RULE20
    status_two[rsl_pkg::B_FAR_BLOCK_COUNT] = far_block_count_nonzero_in; // RULE20
    status_two[rsl_pkg::B_PBIT_COUNT] = pbit_count_nonzero_in; // RULE20
    status_two[rsl_pkg::B_FRAME_COUNT] = frame_count_nonzero_in; // RULE20
    // c-bit counts do not exist in m23 framing
    if (m23_mode)
    begin
      status_two = status_two & ~rsl_pkg::MASK_M23_ZERO; // RULE17
    end
  end

  // set terms for latch one; nothing fires until the samples are primed
  always_comb
  begin
    // levels latch on a change either way; unused status bits stay zero
    set_one = (prev_one ^ status_one) // RULE2 RULE3 RULE4 RULE5
      & {rsl_pkg::REG_W{primed}}; // RULE7 RULE8
    // format mismatch latches on the rise only
    set_one[rsl_pkg::B_FORMAT_MISMATCH] = primed & rose(prev_one[rsl_pkg::B_FORMAT_MISMATCH],
      status_one[rsl_pkg::B_FORMAT_MISMATCH]); // RULE1
    // a reload with the same alignment is not a change; it has its own guard
    set_one[rsl_pkg::B_ALIGN_CHANGE] = align_load_in & align_valid
      & (align_value_in != prev_align); // RULE6
  end

  // set terms for latch two
  always_comb
  begin
    set_two = rsl_pkg::RESET_REG;
    set_two[rsl_pkg::B_CBIT_ERR] = cbit_parity_err_in; // RULE9
    set_two[rsl_pkg::B_FAR_BLOCK_ERR] = far_block_err_in; // RULE10
    set_two[rsl_pkg::B_PBIT_ERR] = pbit_parity_err_in; // RULE11
    set_two[rsl_pkg::B_FRAME_ERR] = frame_err_event_in[fe_sel]; // RULE12
    set_two[rsl_pkg::B_CBIT_COUNT] = primed & rose(prev_two[rsl_pkg::B_CBIT_COUNT],
      status_two[rsl_pkg::B_CBIT_COUNT]); // RULE13
    set_two[rsl_pkg::B_FAR_BLOCK_COUNT] = primed & rose(prev_two[rsl_pkg::B_FAR_BLOCK_COUNT],
      status_two[rsl_pkg::B_FAR_BLOCK_COUNT]); // RULE14
    set_two[rsl_pkg::B_PBIT_COUNT] = primed & rose(prev_two[rsl_pkg::B_PBIT_COUNT],
      status_two[rsl_pkg::B_PBIT_COUNT]); // RULE15
    set_two[rsl_pkg::B_FRAME_COUNT] = primed & rose(prev_two[rsl_pkg::B_FRAME_COUNT],
      status_two[rsl_pkg::B_FRAME_COUNT]); // RULE16
  end

  // write-one-to-clear masks from the accepted write
  always_comb
  begin
    clr_one = rsl_pkg::RESET_REG;
    clr_two = rsl_pkg::RESET_REG;
    if (wr_now && hit(paddr_in, rsl_pkg::IDX_LATCH_ONE))
    begin
      clr_one = pwdata_in[rsl_pkg::REG_W-1:0]; // RULE21
    end
    if (wr_now && hit(paddr_in, rsl_pkg::IDX_LATCH_TWO))
    begin
      clr_two = pwdata_in[rsl_pkg::REG_W-1:0]; // RULE21
    end
  end

  // next latch values; a set in the clearing cycle wins so no event is lost
  always_comb
  begin
    next_latch_one = ((latch_one & ~clr_one) | set_one) & rsl_pkg::MASK_ONE; // RULE21
    next_latch_two = ((latch_two & ~clr_two) | set_two) & rsl_pkg::MASK_TWO; // RULE21
    if (m23_mode)
    begin
      // c-bit and far-end latches stay clear whatever arrives
      next_latch_two = next_latch_two & ~rsl_pkg::MASK_M23_ZERO; // RULE17
    end
  end

  // latch registers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      latch_one <= rsl_pkg::RESET_REG;
      latch_two <= rsl_pkg::RESET_REG;
    end
    else if (clk_en_in)
    begin
      latch_one <= next_latch_one;
      latch_two <= next_latch_two;
    end
  end

  // previous samples; first enabled cycle after reset only primes them
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prev_one <= rsl_pkg::RESET_REG;
      prev_two <= rsl_pkg::RESET_REG;
      primed <= 1'b0;
    end
    else if (clk_en_in)
    begin
      prev_one <= status_one;
      prev_two <= status_two;
      primed <= 1'b1;
    end
  end

  // last alignment loaded into the frame counters
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prev_align <= {rsl_pkg::ALIGN_W{1'b0}};
      align_valid <= 1'b0;
    end
    else if (clk_en_in && align_load_in)
    begin
      prev_align <= align_value_in;
      align_valid <= 1'b1;
    end
  end

  // enable and control registers; reserved bits are forced to zero
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      enable_one <= rsl_pkg::RESET_REG; // RULE19
      enable_two <= rsl_pkg::RESET_REG; // RULE19
      control <= rsl_pkg::RESET_REG;
    end
    else if (clk_en_in && wr_now)
    begin
      if (hit(paddr_in, rsl_pkg::IDX_ENABLE_ONE))
      begin
        enable_one <= pwdata_in[rsl_pkg::REG_W-1:0] & rsl_pkg::MASK_ONE; // RULE19
      end
      if (hit(paddr_in, rsl_pkg::IDX_ENABLE_TWO))
      begin
        enable_two <= pwdata_in[rsl_pkg::REG_W-1:0] & rsl_pkg::MASK_TWO; // RULE19
      end
      if (hit(paddr_in, rsl_pkg::IDX_CONTROL))
      begin
        control <= pwdata_in[rsl_pkg::REG_W-1:0] & rsl_pkg::MASK_CONTROL;
      end
    end
  end

  // read mux over the mapped registers
  always_comb
  begin
    rd_word = rsl_pkg::RESET_REG;
    rd_hit = 1'b1;
    if (hit(paddr_in, rsl_pkg::IDX_STATUS_ONE))
    begin
      rd_word = status_one;
    end
    else if (hit(paddr_in, rsl_pkg::IDX_STATUS_TWO))
    begin
      rd_word = status_two; // RULE20
    end
    else if (hit(paddr_in, rsl_pkg::IDX_LATCH_ONE))
    begin
      rd_word = latch_one;
    end
    else if (hit(paddr_in, rsl_pkg::IDX_LATCH_TWO))
    begin
      rd_word = latch_two;
    end
    else if (hit(paddr_in, rsl_pkg::IDX_ENABLE_ONE))
    begin
      rd_word = enable_one;
    end
    else if (hit(paddr_in, rsl_pkg::IDX_ENABLE_TWO))
    begin
      rd_word = enable_two;
    end
    else if (hit(paddr_in, rsl_pkg::IDX_CONTROL))
    begin
      rd_word = control;
    end
    else
    begin
      // unmapped: zero data and an error answer
      rd_hit = 1'b0;
    end
  end

  // apb answer: ready one cycle after a setup seen with the clock enable high, so such an access has no wait state
  // in the access phase; data is captured at setup because the address is stable
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= {rsl_pkg::DATA_W{1'b0}};
    end
    else if (clk_en_in)
    begin
      if (psel_in && !penable_in)
      begin
        // setup phase seen: answer in the access phase
        pready_out <= 1'b1;
        pslverr_out <= ~rd_hit;
        prdata_out <= pwrite_in ? {rsl_pkg::DATA_W{1'b0}}
                                : {{(rsl_pkg::DATA_W-rsl_pkg::REG_W){1'b0}}, rd_word};
      end
      else
      begin
        // completed or idle: drop the answer
        pready_out <= 1'b0;
        pslverr_out <= 1'b0;
        prdata_out <= {rsl_pkg::DATA_W{1'b0}};
      end
    end
  end

  // interrupt: or of enabled set latches, gated by this port's global enable
  always_comb
  begin
    next_irq = (|(latch_one & enable_one)) | (|(latch_two & enable_two)); // RULE22
    next_irq = next_irq & port_enable; // RULE18
  end

  // registered interrupt output, one cycle behind the latches
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      irq_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      irq_out <= next_irq; // RULE18
    end
  end

endmodule // rsl_latch_irq

// >>> sim/rsl_latch_irq_checker.sv
// port-level assertions for the status latch block, bound to its ports
module rsl_latch_irq_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rsl_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [rsl_pkg::DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // byte addresses: index times four
  localparam logic [11:0] L1 = rsl_pkg::IDX_LATCH_ONE << 2;
  localparam logic [11:0] L2 = rsl_pkg::IDX_LATCH_TWO << 2;
  localparam logic [11:0] BAD = 12'h4c4; // first word past the map
  logic rd_acc; // a good read completing this cycle
  assign rd_acc = pready_out && !pwrite_in && !pslverr_out;
  property p_ready;
    psel_in && !penable_in && clk_en_in |=> pready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_one;
    pready_out && clk_en_in |=> !pready_out;
  endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err;
    pslverr_out |-> pready_out;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hi;
    pready_out |-> prdata_out[31:16] == 16'h0000;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits not zero");
  property p_idle;
    !pready_out |-> prdata_out == 32'h0000_0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_irq_rst;
    $fell(reset_in) |-> !irq_out;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
  property p_rsv1;
    rd_acc && paddr_in == L1 |-> prdata_out[15:12] == 4'h0;
  endproperty
  a_rsv1: assert property (p_rsv1) else $error("latch one spare bits set");
  property p_rsv2;
    rd_acc && paddr_in == L2 |-> prdata_out[15:12] == 4'h0 && prdata_out[7:4] == 4'h0;
  endproperty
  a_rsv2: assert property (p_rsv2) else $error("latch two spare bits set");
  property p_bad;
    pready_out && paddr_in == BAD |-> pslverr_out && prdata_out == 32'h0000_0000;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped access accepted");
  // main scenarios seen
  c_write: cover property (pready_out && pwrite_in);
  c_read: cover property (rd_acc && paddr_in == L1);
  c_irq: cover property ($rose(irq_out));
  c_bad: cover property (pslverr_out);
endmodule // rsl_latch_irq_checker

bind rsl_latch_irq rsl_latch_irq_checker u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .irq_out(irq_out));

// >>> sim/tb_rsl_latch_irq.sv
// self-checking bench for the receive status latch block
module tb_rsl_latch_irq;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PORT = 2; // not port 0, so a wrong bit pick shows
  localparam logic [11:0] L1 = rsl_pkg::IDX_LATCH_ONE << 2;
  localparam logic [11:0] L2 = rsl_pkg::IDX_LATCH_TWO << 2;
  localparam logic [11:0] E1 = rsl_pkg::IDX_ENABLE_ONE << 2;
  localparam logic [11:0] E2 = rsl_pkg::IDX_ENABLE_TWO << 2;
  localparam logic [11:0] CT = rsl_pkg::IDX_CONTROL << 2;
  localparam logic [11:0] S2 = rsl_pkg::IDX_STATUS_TWO << 2;
  localparam logic [11:0] S1 = rsl_pkg::IDX_STATUS_ONE << 2;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1; // clock enable, dropped only in t_hold
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, irq, erv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [11:0] st = 12'h000; // status levels in latch one bit order, bit 5 unused
  logic [2:0] ev = 3'h0; // cbit, far block, pbit event pulses
  logic [3:0] fe = 4'h0, cnt = 4'h0; // framing events, count nonzero levels
  logic ald = 1'b0;
  logic [7:0] aval = 8'h00;
  int n_mismatch = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  rsl_latch_irq #(.PORT_INDEX(PORT)) u_dut (
    .clk_in(clk), .reset_in(rst), .clk_en_in(ce), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .format_mismatch_status_in(st[11]),
    .app_id_channel_status_in(st[10]), .idle_signal_status_in(st[9]),
    .unframed_ones_status_in(st[8]), .multiframe_lost_status_in(st[7]),
    .severe_frame_err_status_in(st[6]), .frame_lost_status_in(st[4]),
    .remote_defect_status_in(st[3]), .alarm_indication_status_in(st[2]),
    .out_of_frame_status_in(st[1]), .no_input_signal_status_in(st[0]),
    .cbit_parity_err_in(ev[2]), .far_block_err_in(ev[1]), .pbit_parity_err_in(ev[0]),
    .frame_err_event_in(fe), .cbit_count_nonzero_in(cnt[3]),
    .far_block_count_nonzero_in(cnt[2]), .pbit_count_nonzero_in(cnt[1]),
    .frame_count_nonzero_in(cnt[0]), .align_load_in(ald), .align_value_in(aval),
    .irq_out(irq));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; an idle edge first so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1)
      chk("apb answer", 32'h1, {31'h0, pready});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdv);
  endtask
  // one-cycle pulse on event and alignment inputs
  task automatic pulse(input logic [2:0] e, input logic [3:0] f, input logic l, logic [7:0] v);
    @(posedge clk);
    ev <= e;
    fe <= f;
    ald <= l;
    aval <= v;
    @(posedge clk);
    ev <= 3'h0;
    fe <= 4'h0;
    ald <= 1'b0;
  endtask
  // reset values, spare bits and the unmapped word
  task automatic t_reset;
    rd("latch_one", L1, 32'h0);
    rd("latch_two", L2, 32'h0);
    rd("enable_one", E1, 32'h0);
    rd("enable_two", E2, 32'h0);
    rd("unmapped", 12'h4c4, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, erv});
    wr(E1, 32'hffff);
    rd("enable_one spare", E1, 32'h0fff);
    wr(E2, 32'hffff);
    rd("enable_two spare", E2, 32'h0f0f);
    wr(E1, 32'h0);
    wr(E2, 32'h0);
  endtask
  // each level in both directions; format mismatch only on the rise
  task automatic t_change;
    for (int i = 0; i < 12; i++)
    begin
      if (i == 5)
        continue;
      @(posedge clk);
      st[i] <= 1'b1;
      rd("rise", L1, 32'h1 << i);
      wr(L1, 32'h0);
      rd("zero write", L1, 32'h1 << i);
      wr(L1, 32'h1 << i);
      rd("cleared", L1, 32'h0);
      @(posedge clk);
      st[i] <= 1'b0;
      rd("fall", L1, i == 11 ? 32'h0 : 32'h1 << i);
      wr(L1, 32'hffff);
    end
  endtask
  // the first load only primes; a repeat is no change
  task automatic t_align;
    pulse(3'h0, 4'h0, 1'b1, 8'h3c);
    pulse(3'h0, 4'h0, 1'b1, 8'h3c);
    rd("align same", L1, 32'h0);
    pulse(3'h0, 4'h0, 1'b1, 8'hc3);
    rd("align new", L1, 32'h20);
    wr(L1, 32'h20);
  endtask
  // error events, and every framing error type select value
  task automatic t_events;
    for (int j = 0; j < 3; j++)
    begin
      pulse(3'h1 << j, 4'h0, 1'b0, 8'h00);
      rd("error event", L2, 32'h200 << j);
      wr(L2, 32'hffff);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(CT, k << 1);
      pulse(3'h0, 4'h1 << ((k + 1) % 4), 1'b0, 8'h00);
      rd("frame other", L2, 32'h0);
      pulse(3'h0, 4'h1 << k, 1'b0, 8'h00);
      rd("frame pick", L2, 32'h100);
      wr(L2, 32'hffff);
    end
    wr(CT, 32'h0);
  endtask
  // count nonzero rises latch, falls do not
  task automatic t_count;
    for (int j = 0; j < 4; j++)
    begin
      @(posedge clk);
      cnt[j] <= 1'b1;
      rd("count rise", L2, 32'h1 << j);
      wr(L2, 32'hffff);
      @(posedge clk);
      cnt[j] <= 1'b0;
      rd("count fall", L2, 32'h0);
    end
    @(posedge clk);
    cnt <= 4'hf;
    rd("status_two", S2, 32'hf);
    wr(L2, 32'hffff);
  endtask
  // m23 keeps the cbit and far block group at zero
  task automatic t_m23;
    wr(CT, 32'h1);
    pulse(3'h7, 4'h0, 1'b0, 8'h00);
    rd("m23 status", S2, 32'h3);
    rd("m23 events", L2, 32'h200);
    @(posedge clk);
    cnt <= 4'h0;
    @(posedge clk);
    cnt <= 4'hf;
    rd("m23 counts", L2, 32'h203);
    @(posedge clk);
    cnt <= 4'h0;
    wr(CT, 32'h0);
    wr(L2, 32'hffff);
  endtask
  // interrupt needs latch, enable and this port's global bit
  task automatic t_irq;
    @(posedge clk);
    st[1] <= 1'b1;
    wr(E1, 32'h2);
    wr(CT, 32'hf0 & ~(32'h10 << PORT));
    repeat (2) @(posedge clk);
    chk("irq other ports", 32'h0, {31'h0, irq});
    wr(CT, 32'h10 << PORT);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(E1, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq disabled", 32'h0, {31'h0, irq});
    wr(E1, 32'h2);
    wr(L1, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    pulse(3'h1, 4'h0, 1'b0, 8'h00);
    wr(E2, 32'h200);
    repeat (2) @(posedge clk);
    chk("irq latch two", 32'h1, {31'h0, irq});
  endtask
  // status one and control read back; a pulse while the clock enable is low is lost
  task automatic t_hold;
    rd("status_one", S1, 32'h2);
    rd("control", CT, 32'h40);
    @(posedge clk);
    ce <= 1'b0;
    st[0] <= 1'b1;
    repeat (3) @(posedge clk);
    st[0] <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    rd("frozen", L1, 32'h0);
    chk("irq held", 32'h1, {31'h0, irq});
  endtask
  // verdict and end of run
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog: the sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_change();
    t_align();
    t_events();
    t_count();
    t_m23();
    t_irq();
    t_hold();
    results();
  end
endmodule // tb_rsl_latch_irq
